// ---- core/rtcs_i2c_slave.sv ----
/*
  Serial two-wire slave port with user bytes, event time stamp and a write FIFO.
  Assumes an external master drives SCL; SDA is open drain, resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none

module rtcs_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire empty = (wp_q == rp_q);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_q[AW-1:0]];

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      wp_q <= wp_q + (AW+1)'(push);
      rp_q <= rp_q + (AW+1)'(pop);
    end
  end
endmodule : rtcs_fifo

module rtcs_i2c_slave
  import rtcs_pkg::*;
#(
  parameter logic [6:0] DEV_ID = 7'h2a // arbitrary value
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // clock/calendar register array, bytes 00h-11h
  input wire logic [CCR_BYTES*8-1:0] clock_control_register_array,
  output logic ccr_wr_valid,
  input wire logic ccr_wr_ready,
  output rtcs_wr_t ccr_wr,
  // event logic
  input wire logic event_input_pin,
  input wire logic event_detect_enable,
  input wire logic event_flag_clear,
  output logic event_seen_flag,
  output logic event_detect_output_pin
);
  // two-stage synchronisers, third stage only for edge finding
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic [2:0] evi_s_q;
  logic [5:0] pu_cnt_q;
  logic pu_done_q;
  rtcs_state_t st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  logic rd_q;
  logic addr_phase_q;
  logic mack_q;
  logic drv_low_q;
  logic [7:0] user_q [2];
  logic [7:0] stamp_q [STAMP_BYTES];
  logic flag_q;
  logic det_q;

  wire scl = scl_s_q[1];
  wire sda = sda_s_q[1];
  wire scl_rise = scl_s_q[1] && !scl_s_q[2];
  wire scl_fall = !scl_s_q[1] && scl_s_q[2];
  wire start_det = scl && scl_s_q[2] && !sda && sda_s_q[2];
  wire stop_det = scl && scl_s_q[2] && sda && !sda_s_q[2];
  wire byte_done = scl_fall && (bit_q == BIT_LAST);
  wire id_match = (sh_q[7:1] == DEV_ID);
  wire ev_rise = evi_s_q[1] && !evi_s_q[2];
  wire capture = ev_rise && !flag_q;

  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    return (p == ADDR_STAMP_LAST) ? PTR_RESET : p + 8'h01;
  endfunction : next_ptr

  function automatic logic [7:0] ccr_byte(input logic [CCR_BYTES*8-1:0] a, input int i);
    return a[i*8 +: 8];
  endfunction : ccr_byte

  // read map selection
  wire is_ccr = (ptr_q <= ADDR_CCR_LAST);
  wire is_user = (ptr_q == ADDR_USER0) || (ptr_q == ADDR_USER1);
  wire is_stamp = (ptr_q >= ADDR_STAMP_FIRST) && (ptr_q <= ADDR_STAMP_LAST);
  wire [7:0] ccr_rd = ccr_byte(clock_control_register_array, int'(ptr_q[4:0]));
  wire [7:0] user_rd = user_q[ptr_q[0]];
  wire [2:0] stamp_idx = 3'(ptr_q - ADDR_STAMP_FIRST);
  wire [7:0] stamp_rd = stamp_q[stamp_idx];
  wire [7:0] rd_byte = is_ccr ? ccr_rd : is_user ? user_rd : is_stamp ? stamp_rd : 8'h00;

  // write path through the fifo
  logic fifo_in_ready;
  logic fifo_out_valid;
  rtcs_wr_t fifo_out;
  wire push_wr = byte_done && (st_q == ST_RX) && !addr_phase_q;
  wire push_ok = push_wr && fifo_in_ready;
  wire out_user = (fifo_out.addr == ADDR_USER0) || (fifo_out.addr == ADDR_USER1);
  wire fifo_pop_ready = out_user || ccr_wr_ready;
  wire user_wr = fifo_out_valid && out_user;

  rtcs_fifo #(
    .W($bits(rtcs_wr_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(push_wr),
    .in_ready(fifo_in_ready),
    .in_data({ptr_q, sh_q}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop_ready),
    .out_data(fifo_out)
  );

  assign ccr_wr_valid = fifo_out_valid && !out_user;
  assign ccr_wr = fifo_out;
  assign sda_o = 1'b0; // open drain: only ever pulls low
  assign sda_oe_n = !drv_low_q;
  assign event_seen_flag = flag_q;
  assign event_detect_output_pin = det_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      scl_s_q <= SYNC_IDLE_HIGH;
      sda_s_q <= SYNC_IDLE_HIGH;
      evi_s_q <= SYNC_IDLE_LOW;
    end
    else
    begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      evi_s_q <= {evi_s_q[1:0], event_input_pin};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pu_cnt_q <= '0;
      pu_done_q <= 1'b0;
    end
    else if (!pu_done_q)
    begin
      pu_cnt_q <= pu_cnt_q + 6'h01;
      pu_done_q <= (pu_cnt_q == 6'(POWERUP_CYC - 1));
    end
  end

  // no reset: the stamps and user bytes model battery-backed storage
  always_ff @(posedge core_clk)
  begin
    if (capture)
    begin
      for (int i = 0; i < STAMP_BYTES; i++)
      begin
        stamp_q[i] <= ccr_byte(clock_control_register_array, i);
      end
    end
    if (user_wr)
    begin
      user_q[fifo_out.addr[0]] <= fifo_out.data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      flag_q <= 1'b0;
      det_q <= 1'b0;
    end
    else
    begin
      // set wins over a clear in the same cycle
      flag_q <= capture || (flag_q && !event_flag_clear);
      if (capture && event_detect_enable)
      begin
        det_q <= !det_q;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      bit_q <= '0;
      sh_q <= '0;
      ptr_q <= PTR_RESET;
      rd_q <= 1'b0;
      addr_phase_q <= 1'b0;
      mack_q <= 1'b0;
      drv_low_q <= 1'b0;
    end
    else if (start_det && pu_done_q)
    begin
      st_q <= ST_DEV;
      bit_q <= '0;
      drv_low_q <= 1'b0;
    end
    else if (stop_det)
    begin
      st_q <= ST_IDLE;
      drv_low_q <= 1'b0;
    end
    else
    begin
      if (scl_rise && (st_q == ST_DEV || st_q == ST_RX || st_q == ST_TX))
      begin
        sh_q <= (st_q == ST_TX) ? sh_q : {sh_q[6:0], sda};
        bit_q <= bit_q + 4'h1;
      end
      case (st_q)
        ST_DEV:
        begin
          if (byte_done)
          begin
            st_q <= id_match ? ST_DEVACK : ST_SKIP;
            drv_low_q <= id_match;
            rd_q <= sh_q[0];
          end
        end
        ST_RX:
        begin
          if (byte_done)
          begin
            st_q <= ST_RXACK;
            drv_low_q <= addr_phase_q || fifo_in_ready;
            if (addr_phase_q)
            begin
              ptr_q <= sh_q;
            end
            else if (push_ok)
            begin
              ptr_q <= next_ptr(ptr_q);
            end
            addr_phase_q <= 1'b0;
          end
        end
        ST_DEVACK:
        begin
          if (scl_fall)
          begin
            bit_q <= '0;
            if (rd_q)
            begin
              st_q <= ST_TX;
              sh_q <= {rd_byte[6:0], 1'b0};
              drv_low_q <= !rd_byte[7];
              ptr_q <= next_ptr(ptr_q);
            end
            else
            begin
              st_q <= ST_RX;
              addr_phase_q <= 1'b1;
              drv_low_q <= 1'b0;
            end
          end
        end
        ST_RXACK:
        begin
          if (scl_fall)
          begin
            st_q <= ST_RX;
            bit_q <= '0;
            drv_low_q <= 1'b0;
          end
        end
        ST_TX:
        begin
          if (byte_done)
          begin
            st_q <= ST_TXACK;
            drv_low_q <= 1'b0;
          end
          else if (scl_fall)
          begin
            drv_low_q <= !sh_q[7];
            sh_q <= {sh_q[6:0], 1'b0};
          end
        end
        ST_TXACK:
        begin
          if (scl_rise)
          begin
            mack_q <= !sda;
          end
          if (scl_fall)
          begin
            bit_q <= '0;
            if (mack_q)
            begin
              st_q <= ST_TX;
              sh_q <= {rd_byte[6:0], 1'b0};
              drv_low_q <= !rd_byte[7];
              ptr_q <= next_ptr(ptr_q);
            end
            else
            begin
              st_q <= ST_SKIP;
            end
          end
        end
        default:
        begin
          drv_low_q <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_PTR_WRAP: assert property (
    (st_q == ST_TXACK && scl_fall && mack_q && ptr_q == ADDR_STAMP_LAST) |=> ptr_q == PTR_RESET)
    else $error("pointer did not wrap to zero");
  AST_FLAG_SET: assert property (
    capture |=> flag_q)
    else $error("event flag not set on capture");
  AST_STAMP_HOLD: assert property (
    flag_q && $past(flag_q) |-> $stable(stamp_q[0]) && $stable(stamp_q[5]))
    else $error("stamp changed while flag set");
  AST_DET_TOGGLE: assert property (
    capture && event_detect_enable |=> det_q != $past(det_q))
    else $error("detect pin did not toggle");
  AST_DET_QUIET: assert property (
    !capture |=> $stable(det_q))
    else $error("detect pin moved without event");
  AST_PU_IDLE: assert property (
    !pu_done_q |-> st_q == ST_IDLE && sda_oe_n)
    else $error("bus active during power-up");
  AST_IDLE_REL: assert property (
    st_q == ST_IDLE || st_q == ST_SKIP |-> ##1 (sda_oe_n || st_q == ST_DEV))
    else $error("data driven while idle");
  AST_STOP_IDLE: assert property (
    stop_det && !(start_det && pu_done_q) |=> st_q == ST_IDLE && sda_oe_n)
    else $error("stop did not return to standby");
  AST_ADDR_ACK: assert property (
    st_q == ST_DEV && byte_done && id_match |=> st_q == ST_DEVACK && !sda_oe_n)
    else $error("matching address not acked");
  AST_ADDR_NACK: assert property (
    st_q == ST_DEV && byte_done && !id_match |=> st_q == ST_SKIP && sda_oe_n)
    else $error("mismatch address acked");
  AST_TX_MSB: assert property (
    st_q == ST_DEVACK && scl_fall && rd_q |=> sda_oe_n == $past(rd_byte[7]))
    else $error("first read bit is not msb");
  AST_MNACK: assert property (
    st_q == ST_TXACK && scl_fall && !mack_q |=> st_q == ST_SKIP ##1 sda_oe_n)
    else $error("nack did not end transmission");
endmodule : rtcs_i2c_slave

`default_nettype wire

// ---- core/rtcs_pkg.sv ----
/*
  Constants, types and register map for the serial slave port of the clock chip.
  Assumes a single 50 MHz core clock and a synchronous active-high reset.
*/
// What this block does
// - Two general-purpose bytes at 12h and 13h, kept while on battery.
// - Event input rising edge copies clock/calendar bytes into stamps 14h-19h.
// - Capture also sets event flag and toggles detect pin when enabled.
// - Stamp holds second, minute, hour, date, month, year; no weekday.
// - Only the first event is captured while the event flag is set.
// - Stamp registers have no clear; reset leaves them untouched.
// - Slave only: never drives the serial clock.
// - Bytes travel most significant bit first in both directions.
// - Data changes only while clock low; changes while high are START/STOP.
// - Data pin released after power-up; START ignored during power-up wait.
// - Bus traffic ignored until a START has been seen.
// - STOP returns the serial interface to standby.
// - Transmitter releases data after eight bits; receiver acks on ninth.
// - Device acks address, word address and write data while the FIFO has room; master acks reads.
// - First byte: seven identifier bits then direction bit, 1 read.
// - All seven identifier bits compared; ack only on match.
// - Word address counter resets to 0h and serves current-address reads.
// - Write: START, address byte, word address, data, STOP; each acked.
// - Device keeps sending while master acks; master then sends STOP.
// - Read pointer advances per byte and wraps from 19h to 00h.
// - New event after flag clear overwrites the previous stamp.
package rtcs_pkg;
  localparam int CLK_MHZ = 50;
  localparam int POWERUP_NS = 1000;
  localparam int POWERUP_CYC = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] ADDR_CCR_LAST = 8'h11;
  localparam logic [7:0] ADDR_USER0 = 8'h12;
  localparam logic [7:0] ADDR_USER1 = 8'h13;
  localparam logic [7:0] ADDR_STAMP_FIRST = 8'h14;
  localparam logic [7:0] ADDR_STAMP_LAST = 8'h19;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [2:0] SYNC_IDLE_HIGH = 3'h7;
  localparam logic [2:0] SYNC_IDLE_LOW = 3'h0;
  localparam int CCR_BYTES = 18;
  localparam int STAMP_BYTES = 6;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] BIT_LAST = 4'h8;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } rtcs_wr_t;

  // gray sequence along idle, address, ack, receive, ack, transmit, ack, skip
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_DEVACK = 3'h3,
    ST_RX = 3'h2,
    ST_RXACK = 3'h6,
    ST_TX = 3'h7,
    ST_TXACK = 3'h5,
    ST_SKIP = 3'h4
  } rtcs_state_t;
endpackage : rtcs_pkg

// ---- bench/rtcs_master_model.sv ----
/*
  Behavioural two-wire bus master that drives the slave port under test.
  Assumes each task starts just after a core_clk rising edge and the bus has a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module rtcs_master_model (
  // clock
  input wire logic core_clk,
  // bus lines, sda_drv high means released
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  // four core cycles per half bit: 160 ns bus clock, idle high between frames
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc

  task automatic put_bit(input logic b);
    sda_drv <= b;
    wait_cyc(2);
    scl <= 1'b1;
    wait_cyc(4);
    scl <= 1'b0;
    wait_cyc(2);
  endtask : put_bit

  task automatic get_bit(output logic b);
    sda_drv <= 1'b1;
    wait_cyc(2);
    scl <= 1'b1;
    wait_cyc(2);
    b = sda_line;
    wait_cyc(2);
    scl <= 1'b0;
    wait_cyc(2);
  endtask : get_bit

  task automatic start_cond();
    sda_drv <= 1'b1;
    wait_cyc(3);
    scl <= 1'b1;
    wait_cyc(4);
    sda_drv <= 1'b0;
    wait_cyc(4);
    scl <= 1'b0;
    wait_cyc(2);
  endtask : start_cond

  task automatic stop_cond();
    sda_drv <= 1'b0;
    wait_cyc(3);
    scl <= 1'b1;
    wait_cyc(4);
    sda_drv <= 1'b1;
    wait_cyc(4);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic nb;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i]);
    get_bit(nb);
    ack = ~nb;
  endtask : send_byte

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic bv;
    for (int i = 7; i >= 0; i--)
    begin
      get_bit(bv);
      b[i] = bv;
    end
    put_bit(~ack);
  endtask : recv_byte
endmodule : rtcs_master_model

`default_nettype wire

// ---- bench/rtcs_tb.sv ----
/*
  Self-checking bench for the slave port: reads, writes, time stamp, write FIFO.
  Assumes rtcs_pkg, the design and the master model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
  end

module testbench
  import rtcs_pkg::*;
;
  localparam logic [6:0] ID = 7'h35; // arbitrary value
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sda_m;
  logic sda_o;
  logic sda_oe_n;
  logic [CCR_BYTES*8-1:0] arr = '0;
  logic ccr_wr_valid;
  logic ccr_wr_ready = 1'b1;
  rtcs_wr_t ccr_wr;
  logic ev_pin = 1'b0;
  logic ev_en = 1'b0;
  logic ev_clr = 1'b0;
  logic event_seen_flag;
  logic event_detect_output_pin;
  wire logic sda_w = sda_m & (sda_oe_n | sda_o);
  int fail_count = 0;
  int checks = 0;
  logic [7:0] user_m [2];
  logic [7:0] stamp_m [6];
  rtcs_wr_t q [$];
  logic ack;
  logic [7:0] rb;

  always #10 core_clk = ~core_clk;

  rtcs_master_model m_u (.core_clk(core_clk), .scl(scl), .sda_drv(sda_m), .sda_line(sda_w));

  rtcs_i2c_slave #(.DEV_ID(ID)) dut_u (
    .core_clk(core_clk), .rst(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .clock_control_register_array(arr), .ccr_wr_valid(ccr_wr_valid), .ccr_wr_ready(ccr_wr_ready),
    .ccr_wr(ccr_wr), .event_input_pin(ev_pin), .event_detect_enable(ev_en),
    .event_flag_clear(ev_clr), .event_seen_flag(event_seen_flag),
    .event_detect_output_pin(event_detect_output_pin)
  );

  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    if (a < ADDR_USER0)
      return arr[a*8 +: 8];
    if (a < ADDR_STAMP_FIRST)
      return user_m[a - ADDR_USER0];
    if (a <= ADDR_STAMP_LAST)
      return stamp_m[a - ADDR_STAMP_FIRST];
    return 8'h00;
  endfunction : exp_byte

  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic addr_phase(input logic [7:0] a);
    m_u.start_cond();
    m_u.send_byte({ID, 1'b0}, ack);
    `CHK("id ack", 1'b1, ack)
    m_u.send_byte(a, ack);
    `CHK("addr ack", 1'b1, ack)
  endtask : addr_phase

  task automatic read_chk(input logic [7:0] a, input int n);
    addr_phase(a);
    m_u.start_cond();
    m_u.send_byte({ID, 1'b1}, ack);
    `CHK("rd id ack", 1'b1, ack)
    for (int i = 0; i < n; i++)
    begin
      m_u.recv_byte(i < n - 1, rb);
      `CHK("rd data", exp_byte(a), rb)
      a = (a == ADDR_STAMP_LAST) ? PTR_RESET : a + 8'h01;
    end
    `CHK("released", 1'b1, sda_oe_n)
    m_u.stop_cond();
  endtask : read_chk

  task automatic write_seq(input logic [7:0] a, input int n, input int n_ok);
    logic [7:0] d;
    addr_phase(a);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      if (a == ADDR_USER0 || a == ADDR_USER1)
        user_m[a - ADDR_USER0] = d;
      else if (i < n_ok)
        q.push_back(rtcs_wr_t'({a, d}));
      m_u.send_byte(d, ack);
      `CHK("wr ack", i < n_ok, ack)
      a = a + 8'h01;
    end
    m_u.stop_cond();
  endtask : write_seq

  task automatic rand_arr();
    for (int i = 0; i < CCR_BYTES; i++)
      arr[i*8 +: 8] <= 8'($urandom);
    @(posedge core_clk);
  endtask : rand_arr

  task automatic event_step(input logic en, input logic take, input logic det);
    ev_en <= en;
    rand_arr();
    if (take)
      for (int i = 0; i < STAMP_BYTES; i++)
        stamp_m[i] = arr[i*8 +: 8];
    ev_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    ev_pin <= 1'b0;
    `CHK("flag", 1'b1, event_seen_flag)
    `CHK("detect", det, event_detect_output_pin)
    read_chk(ADDR_STAMP_FIRST, 8);
  endtask : event_step

  task automatic fifo_drain();
    rtcs_wr_t e;
    for (int k = 0; k < 400 && q.size() > 0; k++)
    begin
      @(posedge core_clk);
      if (ccr_wr_valid === 1'b1 && ccr_wr_ready === 1'b1)
      begin
        e = q.pop_front();
        `CHK("fifo out", e, ccr_wr)
      end
      ccr_wr_ready <= 1'($urandom);
    end
    `CHK("fifo left", 0, q.size())
  endtask : fifo_drain

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    end_sim();
  end

  initial
  begin
    void'($urandom(64567));
    rand_arr();
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    `CHK("oe idle", 1'b1, sda_oe_n)
    `CHK("flag rst", 1'b0, event_seen_flag)
    // start falls inside the power-up wait
    m_u.start_cond();
    m_u.send_byte({ID, 1'b1}, ack);
    `CHK("early ack", 1'b0, ack)
    m_u.stop_cond();
    m_u.start_cond();
    m_u.send_byte({ID, 1'b1}, ack);
    `CHK("cur ack", 1'b1, ack)
    m_u.recv_byte(1'b0, rb);
    `CHK("cur data", exp_byte(PTR_RESET), rb)
    m_u.stop_cond();
    $display("test reset and current read done");
    m_u.start_cond();
    m_u.send_byte({ID ^ 7'h40, 1'b0}, ack);
    `CHK("bad id ack", 1'b0, ack)
    m_u.send_byte(8'h12, ack);
    `CHK("ignored ack", 1'b0, ack)
    m_u.stop_cond();
    $display("test address mismatch done");
    event_step(1'b1, 1'b1, 1'b1);
    event_step(1'b1, 1'b0, 1'b1);
    ev_clr <= 1'b1;
    @(posedge core_clk);
    ev_clr <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK("flag clr", 1'b0, event_seen_flag)
    event_step(1'b0, 1'b1, 1'b1);
    $display("test time stamp done");
    write_seq(ADDR_USER0, 2, 2);
    read_chk(ADDR_CCR_LAST, 4);
    $display("test user bytes done");
    // mid-run reset: storage must survive, first start after the power-up wait
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (60) @(posedge core_clk);
    `CHK("oe rst2", 1'b1, sda_oe_n)
    `CHK("flag rst2", 1'b0, event_seen_flag)
    `CHK("detect rst2", 1'b0, event_detect_output_pin)
    read_chk(ADDR_USER0, 8);
    $display("test reset keeps storage done");
    ccr_wr_ready <= 1'b0;
    write_seq(8'h00, FIFO_DEPTH + 1, FIFO_DEPTH);
    fifo_drain();
    $display("test write buffer done");
    end_sim();
  end
endmodule : testbench

`default_nettype wire
